// ==== hw/ccr_regs.sv ====
// control and system register set of the core, with an axi4-lite window
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
// Behaviour
// - status word resets to mode-bank-block, mask ones
// - reserved status bits read zero, writes dropped
// - mode bit: 0 user, 1 privileged
// - bank select forced one on reset/exception
// - block bit masks irqs; non-break exception then resets
// - fp disable cleared by reset; traps fp ops
// - irq mask bits 7..4; unchanged by irq
// - exception saves status, address and r15
// - vector base resets zero; debug base on user_break_debug_enable
// - return link captures calls, feeds returns
// - instruction pointer resets to a0000000
// - mac pair supplies addend, takes results
// - fp word resets 00040001, top bits zero
// - fp bank swap bit 21 selects banks
// - fp move size bit 20: 32/64
// - precision bit 19; size plus precision reserved
// - denormal bit 18 flushes denormals to zero
// - cause 17..12, enable 11..7, flag 6..2
// - op clears cause; exceptions set sticky flags
// - rounding field 1..0: nearest or zero
// - window decodes in two aliased areas
// - untranslated user access to upper area: address error
module ccr_regs (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // axi4-lite slave
  input wire logic [7:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  output logic s_wready_o,
  output logic [1:0] s_bresp_o,
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  input wire logic [7:0] s_araddr_i,
  input wire logic s_arvalid_i,
  output logic s_arready_o,
  output logic [31:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  output logic s_rvalid_o,
  input wire logic s_rready_i,
  // pipeline side
  input wire ccr_pkg::ccr_exc_t exc_i,
  input wire logic ip_load_i,
  input wire logic [31:0] ip_next_i,
  input wire logic call_i,
  input wire logic [31:0] call_ret_i,
  input wire logic mac_wr_i,
  input wire logic [63:0] mac_res_i,
  input wire ccr_pkg::ccr_fpop_t fpop_i,
  input wire logic fp_instr_i,
  input wire logic fp_in_slot_i,
  input wire logic mmr_req_i,
  input wire logic [31:0] mmr_addr_i,
  input wire logic mmr_translated_i,
  input wire logic priv_reg_acc_i,
  output logic [31:0] instr_pointer_o,
  output logic [31:0] return_link_o,
  output logic [63:0] mac_addend_o,
  output logic [31:0] vector_base_o,
  output logic privilege_mode_bit_o,
  output logic gpr_bank_select_o,
  output logic irq_block_o,
  output logic [3:0] irq_mask_level_o,
  output logic fp_bank_swap_o,
  output logic fp_move_size_o,
  output logic fp_double_o,
  output logic denorm_flush_o,
  output logic [1:0] round_select_o,
  output logic fp_disable_trap_o,
  output logic fp_slot_disable_trap_o,
  output logic block_reset_o,
  output logic mmr_hit_o,
  output logic addr_error_o,
  output logic illegal_instr_o
);
  ////////////////////////////////////////////////////////////////////////////
  // register storage
  logic [31:0] processor_status_word; // only writable bits ever get set
  logic [31:0] saved_status_word;
  logic [31:0] saved_instr_pointer;
  logic [31:0] global_base_pointer;
  logic [31:0] vector_base_pointer;
  logic [31:0] saved_stack_gpr;
  logic [31:0] debug_handler_base;
  logic [31:0] mac_accum_high;
  logic [31:0] mac_accum_low;
  logic [31:0] return_link;
  logic [31:0] instr_pointer;
  logic [31:0] fp_status_control;
  logic [31:0] fp_transfer_port;
  logic [31:0] break_control_word;
  // bus state
  logic aw_held; // write address captured
  logic w_held; // write data captured
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  // byte-lane merge of a write word into a register, with a write mask
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb, input logic [31:0] wm);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    merge = r & wm;
  endfunction

  // address decode of the write path; the read path decodes in its own mux
  function automatic logic known(input logic [7:0] a);
    known = (a <= ccr_pkg::OFS_BREAK_CTRL) && (a[1:0] == 2'h0);
  endfunction

  wire logic user_mode = ~processor_status_word[ccr_pkg::SR_MODE];

  ////////////////////////////////////////////////////////////////////////////
  // axi write channels: address and data accepted in either order
  assign s_awready_o = ~aw_held & ~s_bvalid_o;
  assign s_wready_o = ~w_held & ~s_bvalid_o;
  assign wr_go = aw_held & w_held & ~s_bvalid_o;
  assign wr_hit = known(aw_addr);

  // capture address and data, release on the edge that performs the write and raises the response
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (s_awvalid_i && s_awready_o) begin
        aw_held <= 1'b1;
        aw_addr <= s_awaddr_i;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_wvalid_i && s_wready_o) begin
        w_held <= 1'b1;
        w_data <= s_wdata_i;
        w_strb <= s_wstrb_i;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response: one cycle after both halves are held
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_bvalid_o <= 1'b0;
      s_bresp_o <= ccr_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_bvalid_o <= 1'b1;
      s_bresp_o <= wr_hit ? ccr_pkg::RESP_OKAY : ccr_pkg::RESP_SLVERR;
    end else if (s_bready_i) begin
      s_bvalid_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read decode, masked so reserved bits read zero
  always_comb begin
    rd_word = 32'h00000000;
    rd_hit = 1'b1;
    if (s_araddr_i == ccr_pkg::OFS_STATUS) begin
      rd_word = processor_status_word & ccr_pkg::SR_WMASK;
    end else if (s_araddr_i == ccr_pkg::OFS_SAVED_STATUS) begin
      rd_word = saved_status_word;
    end else if (s_araddr_i == ccr_pkg::OFS_SAVED_IP) begin
      rd_word = saved_instr_pointer;
    end else if (s_araddr_i == ccr_pkg::OFS_GBASE) begin
      rd_word = global_base_pointer;
    end else if (s_araddr_i == ccr_pkg::OFS_VBASE) begin
      rd_word = vector_base_pointer;
    end else if (s_araddr_i == ccr_pkg::OFS_SAVED_STACK) begin
      rd_word = saved_stack_gpr;
    end else if (s_araddr_i == ccr_pkg::OFS_DBG_BASE) begin
      rd_word = debug_handler_base;
    end else if (s_araddr_i == ccr_pkg::OFS_MAC_HIGH) begin
      rd_word = mac_accum_high;
    end else if (s_araddr_i == ccr_pkg::OFS_MAC_LOW) begin
      rd_word = mac_accum_low;
    end else if (s_araddr_i == ccr_pkg::OFS_RET_LINK) begin
      rd_word = return_link;
    end else if (s_araddr_i == ccr_pkg::OFS_IP) begin
      rd_word = instr_pointer;
    end else if (s_araddr_i == ccr_pkg::OFS_FP_CTRL) begin
      rd_word = fp_status_control & ccr_pkg::FP_WMASK;
    end else if (s_araddr_i == ccr_pkg::OFS_FP_XFER) begin
      rd_word = fp_transfer_port;
    end else if (s_araddr_i == ccr_pkg::OFS_BREAK_CTRL) begin
      rd_word = break_control_word;
    end else begin
      rd_hit = 1'b0; // unmapped: slverr, data zero
    end
  end

  assign s_arready_o = ~s_rvalid_o;

  // read response registered on the same edge that takes the address
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_rvalid_o <= 1'b0;
      s_rdata_o <= 32'h00000000;
      s_rresp_o <= ccr_pkg::RESP_OKAY;
    end else if (s_arvalid_i && s_arready_o) begin
      s_rvalid_o <= 1'b1;
      s_rdata_o <= rd_word;
      s_rresp_o <= rd_hit ? ccr_pkg::RESP_OKAY : ccr_pkg::RESP_SLVERR;
    end else if (s_rready_i) begin
      s_rvalid_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status word: exception entry wins over a bus write in the same cycle
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      processor_status_word <= ccr_pkg::SR_RESET;
    end else if (exc_i.exc) begin
      // mode, bank and block forced; irq mask left as it was
      processor_status_word <= processor_status_word | ccr_pkg::SR_EXC_SET;
    end else if (wr_go && aw_addr == ccr_pkg::OFS_STATUS) begin
      processor_status_word <= merge(processor_status_word, w_data, w_strb,
                                     ccr_pkg::SR_WMASK);
    end
  end

  // saved context captured on every exception or interrupt
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      saved_status_word <= 32'h00000000;
      saved_instr_pointer <= 32'h00000000;
      saved_stack_gpr <= 32'h00000000;
    end else if (exc_i.exc) begin
      saved_status_word <= processor_status_word & ccr_pkg::SR_WMASK;
      saved_instr_pointer <= exc_i.fault_ip;
      saved_stack_gpr <= exc_i.r15;
    end else if (wr_go) begin
      if (aw_addr == ccr_pkg::OFS_SAVED_STATUS) begin
        saved_status_word <= merge(saved_status_word, w_data, w_strb, '1);
      end else if (aw_addr == ccr_pkg::OFS_SAVED_IP) begin
        saved_instr_pointer <= merge(saved_instr_pointer, w_data, w_strb, '1);
      end else if (aw_addr == ccr_pkg::OFS_SAVED_STACK) begin
        saved_stack_gpr <= merge(saved_stack_gpr, w_data, w_strb, '1);
      end
    end
  end

  // software-owned base, fp transfer and break control registers (break control keeps only its enable bit)
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      global_base_pointer <= 32'h00000000;
      vector_base_pointer <= ccr_pkg::VB_RESET;
      debug_handler_base <= 32'h00000000;
      fp_transfer_port <= 32'h00000000;
      break_control_word <= 32'h00000000;
    end else if (wr_go) begin
      if (aw_addr == ccr_pkg::OFS_GBASE) begin
        global_base_pointer <= merge(global_base_pointer, w_data, w_strb, '1);
      end else if (aw_addr == ccr_pkg::OFS_VBASE) begin
        vector_base_pointer <= merge(vector_base_pointer, w_data, w_strb, '1);
      end else if (aw_addr == ccr_pkg::OFS_DBG_BASE) begin
        debug_handler_base <= merge(debug_handler_base, w_data, w_strb, '1);
      end else if (aw_addr == ccr_pkg::OFS_FP_XFER) begin
        fp_transfer_port <= merge(fp_transfer_port, w_data, w_strb, '1);
      end else if (aw_addr == ccr_pkg::OFS_BREAK_CTRL) begin
        break_control_word <= merge(break_control_word, w_data, w_strb, ccr_pkg::USER_BREAK_DEBUG_ENABLE_MASK);
      end
    end
  end

  // mac pair: pipeline result wins over a bus write
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mac_accum_high <= 32'h00000000;
      mac_accum_low <= 32'h00000000;
    end else if (mac_wr_i) begin
      {mac_accum_high, mac_accum_low} <= mac_res_i;
    end else if (wr_go && aw_addr == ccr_pkg::OFS_MAC_HIGH) begin
      mac_accum_high <= merge(mac_accum_high, w_data, w_strb, '1);
    end else if (wr_go && aw_addr == ccr_pkg::OFS_MAC_LOW) begin
      mac_accum_low <= merge(mac_accum_low, w_data, w_strb, '1);
    end
  end

  // return link and instruction pointer (pointer is read-only on the bus)
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      return_link <= 32'h00000000;
      instr_pointer <= ccr_pkg::IP_RESET;
    end else begin
      if (call_i) begin
        return_link <= call_ret_i;
      end else if (wr_go && aw_addr == ccr_pkg::OFS_RET_LINK) begin
        return_link <= merge(return_link, w_data, w_strb, '1);
      end
      if (ip_load_i) begin
        instr_pointer <= ip_next_i;
      end
    end
  end

  // fp status word: an op clears cause, then sets cause and sticky flags
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fp_status_control <= ccr_pkg::FP_RESET;
    end else if (fpop_i.op) begin
      fp_status_control[ccr_pkg::FP_CAUSE_LO +: 6] <= fpop_i.cause;
      // error has no flag bit; flags only ever gain bits here
      fp_status_control[ccr_pkg::FP_FLAG_LO +: 5] <=
        fp_status_control[ccr_pkg::FP_FLAG_LO +: 5] | fpop_i.cause[4:0];
    end else if (wr_go && aw_addr == ccr_pkg::OFS_FP_CTRL) begin
      fp_status_control <= merge(fp_status_control, w_data, w_strb, ccr_pkg::FP_WMASK);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode outputs to the pipeline
  assign privilege_mode_bit_o = processor_status_word[ccr_pkg::SR_MODE];
  assign gpr_bank_select_o = processor_status_word[ccr_pkg::SR_BANK];
  assign irq_block_o = processor_status_word[ccr_pkg::SR_BLOCK];
  assign irq_mask_level_o = processor_status_word[ccr_pkg::SR_IRQ_MASK_LEVEL_LO +: 4];
  assign fp_bank_swap_o = fp_status_control[ccr_pkg::FP_SWAP];
  assign fp_move_size_o = fp_status_control[ccr_pkg::FP_MOVSZ];
  // the reserved size+precision pair is not guarded; software owns it
  assign fp_double_o = fp_status_control[ccr_pkg::FP_PREC];
  assign denorm_flush_o = fp_status_control[ccr_pkg::FP_DENORM];
  assign round_select_o = fp_status_control[1:0];
  assign return_link_o = return_link;
  assign instr_pointer_o = instr_pointer;
  assign mac_addend_o = {mac_accum_high, mac_accum_low};
  // debug base replaces vector base only for the user-break handler
  assign vector_base_o = (exc_i.user_break && |(break_control_word & ccr_pkg::USER_BREAK_DEBUG_ENABLE_MASK)) ?
                         debug_handler_base : vector_base_pointer;

  // traps reported combinationally to the pipeline
  assign fp_disable_trap_o = fp_instr_i & processor_status_word[ccr_pkg::SR_FPDIS]
                             & ~fp_in_slot_i;
  assign fp_slot_disable_trap_o = fp_instr_i & processor_status_word[ccr_pkg::SR_FPDIS]
                                  & fp_in_slot_i;
  // nested general exception while blocked sends the core to reset
  assign block_reset_o = exc_i.exc & ~exc_i.user_break
                         & processor_status_word[ccr_pkg::SR_BLOCK];
  // both aliases hit the same registers
  assign mmr_hit_o = mmr_req_i && (mmr_addr_i[31:26] == ccr_pkg::AREA_LOW ||
                                   mmr_addr_i[31:26] == ccr_pkg::AREA_HIGH);
  assign addr_error_o = mmr_req_i && user_mode && !mmr_translated_i &&
                        mmr_addr_i[31:26] == ccr_pkg::AREA_HIGH;
  assign illegal_instr_o = priv_reg_acc_i & user_mode;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_exc_entry;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      exc_i.exc |=> processor_status_word[ccr_pkg::SR_MODE]
        && processor_status_word[ccr_pkg::SR_BANK] && processor_status_word[ccr_pkg::SR_BLOCK];
  endproperty
  a_exc_entry: assert property (p_exc_entry) else $error("exception did not set mode bits");

  property p_mask_kept;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      exc_i.exc |=> $stable(processor_status_word[ccr_pkg::SR_IRQ_MASK_LEVEL_LO +: 4]);
  endproperty
  a_mask_kept: assert property (p_mask_kept) else $error("irq mask changed on exception");

  property p_save_ctx;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      exc_i.exc |=> saved_instr_pointer == $past(exc_i.fault_ip)
        && saved_stack_gpr == $past(exc_i.r15)
        && saved_status_word == ($past(processor_status_word) & ccr_pkg::SR_WMASK);
  endproperty
  a_save_ctx: assert property (p_save_ctx) else $error("context not saved");

  property p_sr_reserved;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (processor_status_word & ~ccr_pkg::SR_WMASK) == 32'h00000000;
  endproperty
  a_sr_reserved: assert property (p_sr_reserved) else $error("status reserved bit set");

  property p_fp_reserved;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      fp_status_control[31:22] == 10'h000;
  endproperty
  a_fp_reserved: assert property (p_fp_reserved) else $error("fp reserved bit set");

  property p_flag_sticky;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      fpop_i.op |=> (fp_status_control[6:2] & $past(fp_status_control[6:2]))
        == $past(fp_status_control[6:2]);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("fp flag lost");

  property p_fp_trap;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (fp_instr_i && processor_status_word[ccr_pkg::SR_FPDIS])
        |-> (fp_disable_trap_o ^ fp_slot_disable_trap_o);
  endproperty
  a_fp_trap: assert property (p_fp_trap) else $error("fp disable trap missing");

  property p_user_upper;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (mmr_req_i && !processor_status_word[ccr_pkg::SR_MODE] && !mmr_translated_i
        && mmr_addr_i[31:26] == ccr_pkg::AREA_HIGH) |-> addr_error_o && mmr_hit_o;
  endproperty
  a_user_upper: assert property (p_user_upper) else $error("no address error");

  property p_call_link;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      call_i |=> return_link_o == $past(call_ret_i);
  endproperty
  a_call_link: assert property (p_call_link) else $error("return link not captured");
endmodule

// ==== hw/ccr_pkg.sv ====
// package: register indices, field layouts and reset values of the control register set
package ccr_pkg;
  // axi4-lite byte offsets of the register window
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_SAVED_STATUS = 8'h04;
  localparam logic [7:0] OFS_SAVED_IP = 8'h08;
  localparam logic [7:0] OFS_GBASE = 8'h0C;
  localparam logic [7:0] OFS_VBASE = 8'h10;
  localparam logic [7:0] OFS_SAVED_STACK = 8'h14;
  localparam logic [7:0] OFS_DBG_BASE = 8'h18;
  localparam logic [7:0] OFS_MAC_HIGH = 8'h1C;
  localparam logic [7:0] OFS_MAC_LOW = 8'h20;
  localparam logic [7:0] OFS_RET_LINK = 8'h24;
  localparam logic [7:0] OFS_IP = 8'h28;
  localparam logic [7:0] OFS_FP_CTRL = 8'h2C;
  localparam logic [7:0] OFS_FP_XFER = 8'h30;
  localparam logic [7:0] OFS_BREAK_CTRL = 8'h34;
  // status word fields
  localparam int SR_MODE = 30;
  localparam int SR_BANK = 29;
  localparam int SR_BLOCK = 28;
  localparam int SR_FPDIS = 15;
  localparam int SR_IRQ_MASK_LEVEL_LO = 4;
  localparam logic [31:0] SR_WMASK = 32'h700083F3;
  localparam logic [31:0] SR_RESET = 32'h700000F0;
  localparam logic [31:0] SR_EXC_SET = 32'h70000000;
  // fp status word fields
  localparam int FP_SWAP = 21;
  localparam int FP_MOVSZ = 20;
  localparam int FP_PREC = 19;
  localparam int FP_DENORM = 18;
  localparam int FP_CAUSE_LO = 12;
  localparam int FP_FLAG_LO = 2;
  localparam logic [31:0] FP_WMASK = 32'h003FFFFF;
  localparam logic [31:0] FP_RESET = 32'h00040001;
  localparam logic [31:0] IP_RESET = 32'hA0000000;
  localparam logic [31:0] VB_RESET = 32'h00000000;
  localparam logic [31:0] USER_BREAK_DEBUG_ENABLE_MASK = 32'h00000001;
  // memory-mapped window decode
  localparam logic [5:0] AREA_LOW = 6'h07;
  localparam logic [5:0] AREA_HIGH = 6'h3F;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // event from the pipeline
  typedef struct packed {
    logic exc;
    logic user_break;
    logic [31:0] fault_ip;
    logic [31:0] r15;
  } ccr_exc_t;
  typedef struct packed {
    logic op;
    logic [5:0] cause;
  } ccr_fpop_t;
endpackage

// ==== test/ccr_pipe_model.sv ====
// pipeline stand-in that pulses events into the register set
`timescale 1ns/100ps
module ccr_pipe_model (
  input wire logic ref_clk_i,
  output ccr_pkg::ccr_exc_t exc_o,
  output logic ip_load_o,
  output logic [31:0] ip_next_o,
  output logic call_o,
  output logic [31:0] call_ret_o,
  output logic mac_wr_o,
  output logic [63:0] mac_res_o,
  output ccr_pkg::ccr_fpop_t fpop_o
);
  // all strobes idle from time zero
  initial begin
    {exc_o, ip_load_o, ip_next_o, call_o, call_ret_o, mac_wr_o, mac_res_o, fpop_o} = '0;
  end
  ////////////////////////////////////////////////////////////
  // exception entry: one-cycle pulse, payload inverted after release
  task automatic exc(input logic ub, input logic [31:0] ip, input logic [31:0] r15);
    @(posedge ref_clk_i);
    exc_o <= '{1'b1, ub, ip, r15};
    @(posedge ref_clk_i);
    exc_o <= '{1'b0, 1'b0, ~ip, ~r15};
    #1;
  endtask
  // user break marker held as a level for the vector mux
  task automatic ub(input logic v);
    @(posedge ref_clk_i);
    exc_o.user_break <= v;
    #1;
  endtask
  // 0 pointer load, 1 call, 2 mac result, 3 fp op
  task automatic ev(input int k, input logic [63:0] d);
    @(posedge ref_clk_i);
    case (k)
      0: {ip_load_o, ip_next_o} <= {1'b1, d[31:0]};
      1: {call_o, call_ret_o} <= {1'b1, d[31:0]};
      2: {mac_wr_o, mac_res_o} <= {1'b1, d};
      default: fpop_o <= {1'b1, d[5:0]};
    endcase
    @(posedge ref_clk_i);
    {ip_load_o, call_o, mac_wr_o, fpop_o.op} <= '0;
    // stale payloads never look valid
    {ip_next_o, call_ret_o, mac_res_o} <= ~{ip_next_o, call_ret_o, mac_res_o};
    #1;
  endtask
endmodule

// ==== test/ccr_regs_tb.sv ====
// self-checking bench for the control register set
`timescale 1ns/100ps
module ccr_regs_tb;
  logic clk = 0;
  logic rst = 1;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0, maddr = '0;
  logic [3:0] wstrb = 4'hF;
  logic fpi = 0, slot = 0, mreq = 0, mtr = 0, prv = 0;
  logic awready, wready, bvalid, arready, rvalid, ipl, cl, mw;
  logic [1:0] bresp, rresp, rnd;
  logic [31:0] rdata, ipo, rlo, vbo, ipn, cr;
  logic [63:0] maco, mr;
  logic md, rb, bl, fsw, fsz, fdb, dn, trp, strp, brst, hit, aerr, ill;
  logic [3:0] imk;
  ccr_pkg::ccr_exc_t exc;
  ccr_pkg::ccr_fpop_t fpop;
  int fails = 0;
  int checks_done = 0;
  // 250 mhz
  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////
  ccr_pipe_model pm (.ref_clk_i(clk), .exc_o(exc), .ip_load_o(ipl), .ip_next_o(ipn),
    .call_o(cl), .call_ret_o(cr), .mac_wr_o(mw), .mac_res_o(mr), .fpop_o(fpop));
  ccr_regs dut (.ref_clk_i(clk), .sys_rst_i(rst), .s_awaddr_i(awaddr), .s_awvalid_i(awvalid),
    .s_awready_o(awready), .s_wdata_i(wdata), .s_wstrb_i(wstrb), .s_wvalid_i(wvalid),
    .s_wready_o(wready), .s_bresp_o(bresp), .s_bvalid_o(bvalid), .s_bready_i(bready),
    .s_araddr_i(araddr), .s_arvalid_i(arvalid), .s_arready_o(arready), .s_rdata_o(rdata),
    .s_rresp_o(rresp), .s_rvalid_o(rvalid), .s_rready_i(rready), .exc_i(exc),
    .ip_load_i(ipl), .ip_next_i(ipn), .call_i(cl), .call_ret_i(cr), .mac_wr_i(mw),
    .mac_res_i(mr), .fpop_i(fpop), .fp_instr_i(fpi), .fp_in_slot_i(slot), .mmr_req_i(mreq),
    .mmr_addr_i(maddr), .mmr_translated_i(mtr), .priv_reg_acc_i(prv),
    .instr_pointer_o(ipo), .return_link_o(rlo), .mac_addend_o(maco), .vector_base_o(vbo),
    .privilege_mode_bit_o(md), .gpr_bank_select_o(rb), .irq_block_o(bl),
    .irq_mask_level_o(imk), .fp_bank_swap_o(fsw), .fp_move_size_o(fsz), .fp_double_o(fdb),
    .denorm_flush_o(dn), .round_select_o(rnd), .fp_disable_trap_o(trp),
    .fp_slot_disable_trap_o(strp), .block_reset_o(brst), .mmr_hit_o(hit),
    .addr_error_o(aerr), .illegal_instr_o(ill));
  ////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tmo();
    fails++;
    wrap_up();
  endtask
  // axi write: both halves offered, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    @(posedge clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 0;
    if (bvalid !== 1'b1) tmo();
    chk(bresp, er);
  endtask
  // axi read, data taken at the rvalid edge
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    @(posedge clk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 0;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 0;
    if (rvalid !== 1'b1) tmo();
    chk(rdata, e);
    chk(rresp, er);
  endtask
  // pipeline levels: fp instr, slot, mmr req, translated, protected access
  task automatic lv(input logic [4:0] f, input logic [31:0] a);
    @(posedge clk);
    {fpi, slot, mreq, mtr, prv, maddr} <= {f, a};
    #1;
  endtask
  // block reset is combinational, so look while the pulse stands
  task automatic exc_chk(input logic u, input logic br);
    fork
      pm.exc(u, 32'h8C001234, 32'h8C00FFF0);
      begin
        @(posedge clk);
        #1;
        chk(brst, br);
      end
    join
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    logic [1:0] j;
    repeat (3) @(posedge clk);
    rst <= 0;
    rd(8'h00, 32'h700000F0);
    rd(8'h2C, 32'h00040001);
    rd(8'h28, 32'hA0000000);
    rd(8'h10, 32'h00000000);
    chk({md, rb, bl, imk}, 7'h7F);
    wr(8'h00, 32'hFFFFFFFF);
    rd(8'h00, 32'h700083F3);
    lv(5'b10000, '0);
    chk({trp, strp}, 2'b10);
    lv(5'b11000, '0);
    chk({trp, strp}, 2'b01);
    wr(8'h00, 32'h000000A0);
    chk({md, rb, bl, trp, strp, imk}, 9'h00A);
    lv(5'b00100, 32'hFC000010);
    chk({hit, aerr}, 2'b11);
    lv(5'b00110, 32'hFC000010);
    chk({hit, aerr}, 2'b10);
    lv(5'b00110, 32'h1C000010);
    chk({hit, aerr}, 2'b10);
    lv(5'b00001, 32'h00000010);
    chk({hit, ill}, 2'b01);
    exc_chk(1'b0, 1'b0);
    rd(8'h04, 32'h000000A0);
    rd(8'h08, 32'h8C001234);
    rd(8'h14, 32'h8C00FFF0);
    chk({md, rb, bl, imk}, 7'h7A);
    lv(5'b00101, 32'hFC000010);
    chk({aerr, ill}, 2'b00);
    exc_chk(1'b1, 1'b0);
    exc_chk(1'b0, 1'b1);
    wr(8'h10, 32'h8C000000);
    wr(8'h18, 32'h8C100000);
    wr(8'h34, 32'h00000001);
    pm.ub(1'b1);
    chk(vbo, 32'h8C100000);
    wr(8'h34, 32'h00000000);
    chk(vbo, 32'h8C000000);
    pm.ub(1'b0);
    pm.ev(1, 64'h8C000456);
    chk(rlo, 32'h8C000456);
    pm.ev(2, 64'h0123456789ABCDEF);
    chk(maco, 64'h0123456789ABCDEF);
    rd(8'h1C, 32'h01234567);
    rd(8'h20, 32'h89ABCDEF);
    pm.ev(0, 64'h8C000100);
    chk(ipo, 32'h8C000100);
    wr(8'h28, 32'h00000000);
    rd(8'h28, 32'h8C000100);
    // precision is low whenever move size is high, so the two never meet
    wr(8'h2C, 32'hFFF7FFFF);
    rd(8'h2C, 32'h0037FFFF);
    for (int i = 0; i < 4; i++) begin
      j = 2'(i);
      wr(8'h2C, {10'h0, j, ~j[0], ~j[1], 16'h0, j});
      chk({fsw, fsz, fdb, dn, rnd}, {j, ~j[0], ~j[1], j});
    end
    wr(8'h2C, 32'h00000000);
    pm.ev(3, 64'h11);
    rd(8'h2C, 32'h00011044);
    pm.ev(3, 64'h04);
    rd(8'h2C, 32'h00004054);
    pm.ev(3, 64'h20);
    rd(8'h2C, 32'h00020054);
    rd(8'h38, 32'h00000000, 2'h2);
    wr(8'h38, 32'h00000001, 2'h2);
    // second reset in mid-run: written words must fall back to reset values
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    rd(8'h00, 32'h700000F0);
    rd(8'h10, 32'h00000000);
    rd(8'h28, 32'hA0000000);
    rd(8'h2C, 32'h00040001);
    chk(ipo, 32'hA0000000);
    wrap_up();
  end
endmodule
